// ### asrc_consts.svh
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
// ----------------------------------------------------------------
// clock and memory timing (slow speed grade, also safe for the fast one)
// ----------------------------------------------------------------
`define ASRC_CLK_NS 5
`define ASRC_T_RC_NS 70
`define ASRC_T_WC_NS 70
`define ASRC_T_CW_NS 70
`define ASRC_T_AW_NS 70
`define ASRC_T_WP_NS 35
`define ASRC_T_DW_NS 30
`define ASRC_T_AA_NS 70
`define ASRC_T_CHZ_NS 35
`define ASRC_T_OHZ_NS 30
// least times round up to whole cycles
`define ASRC_CEIL(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_RC_CYC `ASRC_CEIL(`ASRC_T_RC_NS)
`define ASRC_WC_CYC `ASRC_CEIL(`ASRC_T_WC_NS)
`define ASRC_WP_CYC `ASRC_CEIL(`ASRC_T_WP_NS)
`define ASRC_DW_CYC `ASRC_CEIL(`ASRC_T_DW_NS)
`define ASRC_AA_CYC `ASRC_CEIL(`ASRC_T_AA_NS)
`define ASRC_FLOAT_CYC `ASRC_CEIL(`ASRC_T_CHZ_NS)
// two synchroniser stages on the byte lines
`define ASRC_SYNC_CYC 2
`define ASRC_ADDR_RST 21'h00_0000
`define ASRC_BYTE_RST 8'h00
`endif

// ### asrc_pkg.sv
package asrc_pkg;
	typedef logic [20:0] asrc_addr_t;
	typedef logic [7:0] asrc_byte_t;
	typedef logic [4:0] asrc_cnt_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WRITE,
		ST_WEND,
		ST_READ,
		ST_RFLOAT,
		ST_RETAIN,
		ST_RECOVER
	} asrc_state_t;
endpackage

// ### asrc_timer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// down counter: load a value, o_zero once it has run out
// ----------------------------------------------------------------
module asrc_timer (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// control
	input wire logic i_load,
	input wire asrc_pkg::asrc_cnt_t i_value,
	// status
	output logic o_zero
);
	import asrc_pkg::*;
	asrc_cnt_t cnt_q;
	asrc_cnt_t cnt_d;

	// load wins over counting so a new phase always starts fresh
	always_comb begin
		cnt_d = cnt_q;
		if (i_load) begin
			cnt_d = i_value;
		end else if (cnt_q != 5'h0) begin
			cnt_d = cnt_q - 5'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cnt_q <= 5'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_zero = (cnt_q == 5'h0);
endmodule // asrc_timer

// ### asrc_ctrl.sv
`timescale 1ns/1ps
`include "asrc_consts.svh"
module asrc_ctrl (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// user request
	input wire logic i_req,
	input wire logic i_wr,
	input wire asrc_pkg::asrc_addr_t i_addr,
	input wire asrc_pkg::asrc_byte_t i_wdata,
	input wire logic i_retain,
	// user answer
	output logic o_ready,
	output logic o_done,
	output asrc_pkg::asrc_byte_t o_rdata,
	output logic o_retained,
	// memory pins
	output asrc_pkg::asrc_addr_t o_word_address_lines,
	output logic o_select_low_active_n,
	output logic o_select_high_active,
	output logic o_we_n,
	output logic o_oe_n,
	output asrc_pkg::asrc_byte_t o_byte_lines_out,
	output logic o_byte_lines_oe_n,
	input wire asrc_pkg::asrc_byte_t i_byte_lines_in
);
	import asrc_pkg::*;

	// ----------------------------------------------------------------
	// byte line synchroniser
	// ----------------------------------------------------------------
	asrc_byte_t dq_s1_q;
	asrc_byte_t dq_s2_q;

	// pin data is asynchronous to i_mclk; only the second stage is read
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			dq_s1_q <= `ASRC_BYTE_RST;
			dq_s2_q <= `ASRC_BYTE_RST;
		end else begin
			dq_s1_q <= i_byte_lines_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// phase timer
	// ----------------------------------------------------------------
	logic tmr_load;
	asrc_cnt_t tmr_value;
	logic tmr_zero;

	asrc_timer u_timer (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(tmr_load),
		.i_value(tmr_value),
		.o_zero(tmr_zero)
	);

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	asrc_state_t state_q, state_d;
	asrc_addr_t addr_q, addr_d;
	asrc_byte_t wdata_q, wdata_d;
	asrc_byte_t rdata_q, rdata_d;
	logic sel_n_q, sel_n_d;
	logic sel_hi_q, sel_hi_d;
	logic we_n_q, we_n_d;
	logic oe_n_q, oe_n_d;
	logic dq_oe_n_q, dq_oe_n_d;
	logic done_q, done_d;
	logic ready_q, ready_d;
	logic retained_q, retained_d;

	// next pin levels; all pins leave flops so edges line up on one clock
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		sel_n_d = 1'b1;
		sel_hi_d = 1'b0;
		we_n_d = 1'b1;
		oe_n_d = 1'b1;
		dq_oe_n_d = 1'b1;
		done_d = 1'b0;
		retained_d = 1'b0;
		tmr_load = 1'b0;
		tmr_value = 5'h0;
		case (state_q)
			ST_IDLE: begin
				// retention takes priority over new requests
				if (i_retain) begin
					state_d = ST_RETAIN;
					retained_d = 1'b1;
				end else if (i_req && i_wr) begin
					// selects and strobe fall on the same edge: memory stays floating
					state_d = ST_WRITE;
					addr_d = i_addr;
					wdata_d = i_wdata;
					sel_n_d = 1'b0;
					sel_hi_d = 1'b1;
					we_n_d = 1'b0;
					dq_oe_n_d = 1'b0;
					tmr_load = 1'b1;
					tmr_value = 5'(`ASRC_WC_CYC - 1);
				end else if (i_req) begin
					// address goes out on the selecting edge itself
					state_d = ST_READ;
					addr_d = i_addr;
					sel_n_d = 1'b0;
					sel_hi_d = 1'b1;
					oe_n_d = 1'b0;
					tmr_load = 1'b1;
					tmr_value = 5'(`ASRC_AA_CYC + `ASRC_SYNC_CYC - 1);
				end
			end
			ST_WRITE: begin
				sel_n_d = 1'b0;
				sel_hi_d = 1'b1;
				we_n_d = 1'b0;
				dq_oe_n_d = 1'b0;
				if (tmr_zero) begin
					// strobe and selects end together; data kept one more cycle
					state_d = ST_WEND;
					sel_n_d = 1'b1;
					sel_hi_d = 1'b0;
					we_n_d = 1'b1;
				end
			end
			ST_WEND: begin
				state_d = ST_IDLE;
				done_d = 1'b1;
			end
			ST_READ: begin
				sel_n_d = 1'b0;
				sel_hi_d = 1'b1;
				oe_n_d = 1'b0;
				if (tmr_zero) begin
					// access time plus synchroniser delay has passed
					state_d = ST_RFLOAT;
					rdata_d = dq_s2_q;
					done_d = 1'b1;
					sel_n_d = 1'b1;
					sel_hi_d = 1'b0;
					oe_n_d = 1'b1;
					tmr_load = 1'b1;
					tmr_value = 5'(`ASRC_FLOAT_CYC - 1);
				end
			end
			ST_RFLOAT: begin
				// memory may still drive; the host keeps off the bus meanwhile
				if (tmr_zero) begin
					state_d = ST_IDLE;
				end
			end
			ST_RETAIN: begin
				retained_d = 1'b1;
				if (!i_retain) begin
					state_d = ST_RECOVER;
					tmr_load = 1'b1;
					tmr_value = 5'(`ASRC_RC_CYC - 1);
				end
			end
			ST_RECOVER: begin
				if (tmr_zero) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		ready_d = (state_d == ST_IDLE) && !i_retain;
	end

	// register stage only
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			addr_q <= `ASRC_ADDR_RST;
			wdata_q <= `ASRC_BYTE_RST;
			rdata_q <= `ASRC_BYTE_RST;
			sel_n_q <= 1'b1;
			sel_hi_q <= 1'b0;
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			dq_oe_n_q <= 1'b1;
			done_q <= 1'b0;
			ready_q <= 1'b0;
			retained_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			sel_n_q <= sel_n_d;
			sel_hi_q <= sel_hi_d;
			we_n_q <= we_n_d;
			oe_n_q <= oe_n_d;
			dq_oe_n_q <= dq_oe_n_d;
			done_q <= done_d;
			ready_q <= ready_d;
			retained_q <= retained_d;
		end
	end

	// outputs straight from flops
	assign o_word_address_lines = addr_q;
	assign o_select_low_active_n = sel_n_q;
	assign o_select_high_active = sel_hi_q;
	assign o_we_n = we_n_q;
	assign o_oe_n = oe_n_q;
	assign o_byte_lines_out = wdata_q;
	assign o_byte_lines_oe_n = dq_oe_n_q;
	assign o_done = done_q;
	assign o_rdata = rdata_q;
	assign o_ready = ready_q;
	assign o_retained = retained_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	sequence s_write_start;
		$fell(o_we_n) && !o_select_low_active_n && o_select_high_active;
	endsequence
	sequence s_write_end;
		$rose(o_we_n);
	endsequence

	// address and strobe may move on one edge (zero setup), so only the level before the change counts
	AST_ADDR_CHANGE_WE_HIGH: assert property ($changed(o_word_address_lines) |-> $past(o_we_n))
		else $error("address moved while strobe low");
	AST_WRITE_PULSE: assert property (s_write_start |-> !o_we_n [*7])
		else $error("write strobe pulse too short");
	AST_SELECT_TO_END: assert property (s_write_start |-> ##13 (!o_we_n && !o_select_low_active_n))
		else $error("selects ended before 70 ns");
	AST_SELECT_WITH_STROBE: assert property ($fell(o_we_n) |-> $fell(o_select_low_active_n))
		else $error("strobe fell apart from selects");
	AST_DATA_SETUP: assert property (s_write_end |-> $past(!o_byte_lines_oe_n, 6))
		else $error("write data setup too short");
	AST_DATA_HOLD: assert property (s_write_end |-> !o_byte_lines_oe_n && o_select_low_active_n)
		else $error("data released at or before write end");
	AST_ADDR_TO_END: assert property (s_write_end |-> $past(o_word_address_lines, 14) == o_word_address_lines)
		else $error("address not held through write");
	AST_NO_CONTENTION: assert property ($rose(o_oe_n) |-> o_byte_lines_oe_n [*7])
		else $error("host drove before memory floated");
	AST_READ_STROBE_HIGH: assert property (!o_oe_n |-> o_we_n && o_byte_lines_oe_n)
		else $error("strobe or host drive during read");
	// the address moves only on the selecting edge; after that it must sit still until the read ends
	AST_READ_ADDR: assert property (!o_oe_n && !$fell(o_oe_n) |-> $stable(o_word_address_lines))
		else $error("address moved during read");
	AST_RETAIN_DESELECT: assert property (o_retained |-> o_select_low_active_n && !o_select_high_active)
		else $error("selected during retention");
	AST_RECOVER_WAIT: assert property ($fell(o_retained) |-> o_select_low_active_n [*8])
		else $error("selected too soon after retention");
endmodule // asrc_ctrl

// ### asrc_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// behavioural byte-wide static memory as seen from its pins
// ----------------------------------------------------------------
module asrc_mem_model (
	// memory pins
	input wire asrc_pkg::asrc_addr_t i_addr,
	input wire logic i_sel_n,
	input wire logic i_sel_hi,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	// host side of the byte lines
	input wire asrc_pkg::asrc_byte_t i_host_data,
	input wire logic i_host_oe_n,
	// slow answers use nearly the whole access time
	input wire logic i_slow,
	// resolved byte lines and count of timing faults
	output asrc_pkg::asrc_byte_t o_bus,
	output int o_viol
);
	import asrc_pkg::*;
	asrc_byte_t mem [int];
	realtime t_acc, t_addr, t_sel, t_wlo, t_dat, t_won;
	logic sel, wr_on, drv;
	assign sel = !i_sel_n && i_sel_hi;
	assign wr_on = sel && !i_we_n;
	initial begin
		o_bus = 8'h00;
		o_viol = 0;
	end
	// any address, select, strobe or output enable change restarts the access clock, so drive never starts early
	always @(i_addr or sel or i_oe_n or i_we_n) t_acc = $realtime;
	always @(posedge sel) t_sel = $realtime;
	always @(negedge i_we_n) t_wlo = $realtime;
	always @(i_host_data) t_dat = $realtime;
	always @(i_addr) t_addr = $realtime;
	always @(posedge wr_on) t_won = $realtime;
	// the first edge that drops the overlap ends the write and stores the byte
	always @(negedge wr_on) begin
		// judged at the end so an address moving on the very edge the write starts is not a race
		if (t_addr > t_won) o_viol++;
		if ($realtime - t_dat < 30 || $realtime - t_wlo < 35 || $realtime - t_sel < 70) o_viol++;
		if ($realtime - t_addr < 70 || i_host_oe_n) o_viol++;
		mem[i_addr] = i_host_data;
	end
	// released lines flip every tick so a stale byte never looks valid
	always #1 begin
		drv = sel && !i_oe_n && i_we_n && ($realtime - t_acc >= 10);
		if (drv && !i_host_oe_n) o_viol++;
		if (!i_host_oe_n) o_bus = i_host_data;
		else if (drv && $realtime - t_acc >= (i_slow ? 69 : 40)) o_bus = mem.exists(i_addr) ? mem[i_addr] : 8'h5A;
		// old byte lingers briefly after a bare address change
		else if (sel && !i_oe_n && i_we_n && t_acc == t_addr && $realtime - t_addr < 10) o_bus = o_bus;
		else o_bus = ~o_bus;
	end
endmodule // asrc_mem_model

// ### tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller against the memory model
// ----------------------------------------------------------------
module tb;
	import asrc_pkg::*;
	logic i_mclk = 0, i_rst = 1, i_req = 0, i_wr = 0, i_retain = 0, slow = 0;
	asrc_addr_t i_addr = 21'h00_0000, pin_addr;
	asrc_byte_t i_wdata = 8'h00, rdata, pin_out, bus;
	logic ready, done, retained, sel_n, sel_hi, we_n, oe_n, pin_oe_n;
	int n_fail = 0, tests_run = 0, viol, lat;
	always #2.5 i_mclk = ~i_mclk;
	asrc_ctrl i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_retain(i_retain), .o_ready(ready), .o_done(done), .o_rdata(rdata), .o_retained(retained),
		.o_word_address_lines(pin_addr), .o_select_low_active_n(sel_n), .o_select_high_active(sel_hi),
		.o_we_n(we_n), .o_oe_n(oe_n), .o_byte_lines_out(pin_out), .o_byte_lines_oe_n(pin_oe_n),
		.i_byte_lines_in(bus));
	asrc_mem_model i_mem (.i_addr(pin_addr), .i_sel_n(sel_n), .i_sel_hi(sel_hi), .i_we_n(we_n), .i_oe_n(oe_n),
		.i_host_data(pin_out), .i_host_oe_n(pin_oe_n), .i_slow(slow), .o_bus(bus), .o_viol(viol));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	// inputs move 1 ns after the rising edge, clear of the sampling point
	task automatic step();
		@(posedge i_mclk);
		#1;
	endtask
	// one access; lat counts edges from the taking edge to o_done
	task automatic acc(input logic wr, input asrc_addr_t a, input asrc_byte_t d);
		for (int n = 0; n < 50 && ready !== 1'b1; n++) step();
		i_req = 1;
		i_wr = wr;
		i_addr = a;
		i_wdata = d;
		step();
		i_req = 0;
		for (lat = 0; lat < 40 && done !== 1'b1; lat++) begin
			if (!wr) check(we_n, 1'b1, "strobe in read");
			step();
		end
	endtask
	task automatic t_reset();
		check({sel_n, sel_hi, we_n, oe_n, pin_oe_n}, 5'b10111, "idle pins");
		check(ready, 1'b1, "ready after reset");
		$display("test reset done");
	endtask
	// all four corners of the byte, both ends of the address, prompt and slow memory
	task automatic t_rw();
		asrc_addr_t a [4] = '{21'h00_0000, 21'h1F_FFFF, 21'h0A_AAAA, 21'h15_5555};
		asrc_byte_t d [4] = '{8'h3C, 8'hC3, 8'hFF, 8'h00};
		for (int i = 0; i < 4; i++) begin
			slow = i[0];
			acc(1'b1, a[i], d[i]);
			check(lat, 15, "write latency");
		end
		for (int i = 3; i >= 0; i--) begin
			slow = ~i[0];
			acc(1'b0, a[i], 8'h00);
			check(lat, 16, "read latency");
			check(rdata, d[i], "read byte");
		end
		check(viol, 0, "pin timing");
		$display("test rw done");
	endtask
	// a request shown while busy must be dropped, not queued
	task automatic t_refuse();
		acc(1'b0, 21'h00_0001, 8'h00);
		// the read has ended but its float wait keeps the controller busy
		i_req = 1;
		i_wr = 1;
		i_addr = 21'h1F_FFFF;
		i_wdata = 8'h22;
		step();
		check(ready, 1'b0, "busy during float");
		check({we_n, pin_oe_n}, 2'b11, "no write started while busy");
		i_req = 0;
		acc(1'b1, 21'h00_0001, 8'h11);
		check(lat, 15, "write latency after refusal");
		acc(1'b0, 21'h1F_FFFF, 8'h00);
		check(rdata, 8'hC3, "refused write left no trace");
		acc(1'b0, 21'h00_0001, 8'h00);
		check(rdata, 8'h11, "taken write stored");
		check(viol, 0, "pin timing");
		$display("test refuse done");
	endtask
	// retention deselects; recovery lasts at least one read cycle
	task automatic t_retain();
		int n;
		// retention is only taken from idle, so let the last read float out first
		for (n = 0; n < 50 && ready !== 1'b1; n++) step();
		i_retain = 1;
		repeat (3) step();
		check({retained, sel_n, sel_hi, ready}, 4'b1100, "retention state");
		i_retain = 0;
		for (n = 0; n < 50 && ready !== 1'b1; n++) step();
		check(n >= 14, 1'b1, "recovery length");
		acc(1'b0, 21'h0A_AAAA, 8'h00);
		check(rdata, 8'hFF, "read after retention");
		$display("test retain done");
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_mclk);
		#1 i_rst = 0;
		step();
		t_reset();
		t_rw();
		t_refuse();
		t_retain();
		end_sim();
	end
	// the whole run takes well under 2000 cycles
	initial begin
		#20000;
		n_fail++;
		end_sim();
	end
endmodule // tb
